// *** inc/rdc_consts.svh ***
`ifndef RDC_CONSTS_SVH
`define RDC_CONSTS_SVH

// Timing figures and the system clock rate.
`define RDC_CLK_MHZ 25
`define RDC_PG_DELAY_US 500
`define RDC_HOLD_US 10

// Four-level strap codes.
`define RDC_LVL_0 2'h0
`define RDC_LVL_R 2'h1
`define RDC_LVL_F 2'h2
`define RDC_LVL_1 2'h3

// Target address bits 7..3 for each level of the shared gain/address strap.
`define RDC_ADDR_L0 5'h11
`define RDC_ADDR_LR 5'h08
`define RDC_ADDR_LF 5'h04
`define RDC_ADDR_L1 5'h03

// Register offsets.
`define RDC_OFF_GEN 8'h0A
`define RDC_OFF_EQ01 8'h10
`define RDC_OFF_EQ23 8'h11
`define RDC_OFF_MON 8'h12
`define RDC_OFF_EVT 8'h20

// Register fields and reset values.
`define RDC_GEN_RST 8'h01
`define RDC_GEN_WMASK 8'hBF
`define RDC_GEN_OVR 4
`define RDC_LINK_ON 2'h2
`define RDC_MON_DIS 0
`define RDC_MON_DONE 7
`define RDC_EVT_SW 0
`define RDC_EVT_RD 1
`define RDC_BYTE_BITS 4'h8

`endif

// *** inc/rdc_pkg.sv ***
package rdc_pkg;

  typedef logic [1:0] rdc_lvl_t;

  typedef enum logic [2:0] {
    RDC_IDLE = 3'h0,
    RDC_ADDR = 3'h1,
    RDC_RXD = 3'h2,
    RDC_ACK = 3'h3,
    RDC_TXD = 3'h4,
    RDC_MACK = 3'h5
  } rdc_i2c_e;

endpackage : rdc_pkg

// *** hdl/rdc_i2c_target.sv ***
`timescale 1ns/100ps
`include "rdc_consts.svh"
module rdc_i2c_target
  import rdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic [6:0] devAddr,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic [7:0] txData,
  output logic sdaOe,
  output logic rxValid,
  output logic rxFirst,
  output logic [7:0] rxByte,
  output logic txTake
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic [1:0] sclSy_r, sdaSy_r;
  logic sclD_r, sdaD_r;
  rdc_i2c_e st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic readMode_r, first_r, sdaOe_r, rxValid_r, rxFirst_r, txTake_r;
  logic [7:0] rxByte_r;

  wire sclS = sclSy_r[1];
  wire sdaS = sdaSy_r[1];
  wire sclRise = sclS & ~sclD_r;
  wire sclFall = ~sclS & sclD_r;
  wire startCond = sclS & sclD_r & sdaD_r & ~sdaS;
  wire stopCond = sclS & sclD_r & ~sdaD_r & sdaS;
  wire byteDone = sclFall & (cnt_r == `RDC_BYTE_BITS);
  wire addrHit = (sh_r[7:1] == devAddr);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclSy_r <= 2'h3;
      sdaSy_r <= 2'h3;
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclSy_r <= {sclSy_r[0], sclIn};
      sdaSy_r <= {sdaSy_r[0], sdaIn};
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  // A start or stop anywhere restarts the engine; bits move on SCL edges.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= RDC_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      readMode_r <= 1'b0;
      first_r <= 1'b0;
      sdaOe_r <= 1'b0;
      rxValid_r <= 1'b0;
      rxFirst_r <= 1'b0;
      rxByte_r <= 8'h00;
      txTake_r <= 1'b0;
    end else begin
      rxValid_r <= 1'b0;
      txTake_r <= 1'b0;
      if (!enable || stopCond) begin
        st_r <= RDC_IDLE;
        sdaOe_r <= 1'b0;
      end else if (startCond) begin
        st_r <= RDC_ADDR;
        cnt_r <= 4'h0;
        sdaOe_r <= 1'b0;
      end else begin
        unique case (st_r)
          RDC_IDLE: begin
          end
          RDC_ADDR, RDC_RXD: begin
            if (sclRise) begin
              sh_r <= {sh_r[6:0], sdaS};
              cnt_r <= cnt_r + 4'h1;
            end else if (byteDone && st_r == RDC_ADDR) begin
              st_r <= addrHit ? RDC_ACK : RDC_IDLE;
              sdaOe_r <= addrHit;
              readMode_r <= sh_r[0];
              first_r <= 1'b1;
            end else if (byteDone) begin
              st_r <= RDC_ACK;
              sdaOe_r <= 1'b1;
              rxValid_r <= 1'b1;
              rxFirst_r <= first_r;
              rxByte_r <= sh_r;
              first_r <= 1'b0;
            end
          end
          RDC_ACK: begin
            if (sclFall) begin
              cnt_r <= 4'h0;
              st_r <= readMode_r ? RDC_TXD : RDC_RXD;
              sh_r <= txData;
              sdaOe_r <= readMode_r & ~txData[7];
              txTake_r <= readMode_r;
            end
          end
          RDC_TXD: begin
            if (sclRise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (byteDone) begin
              st_r <= RDC_MACK;
              sdaOe_r <= 1'b0;
            end else if (sclFall) begin
              sh_r <= {sh_r[6:0], 1'b0};
              sdaOe_r <= ~sh_r[6];
            end
          end
          RDC_MACK: begin
            if (sclRise) begin
              st_r <= sdaS ? RDC_IDLE : RDC_ACK;
            end
          end
          default: begin
            st_r <= RDC_IDLE;
          end
        endcase
      end
    end
  end

  assign sdaOe = sdaOe_r;
  assign rxValid = rxValid_r;
  assign rxFirst = rxFirst_r;
  assign rxByte = rxByte_r;
  assign txTake = txTake_r;

  sequence s_addrIn;
    enable && !startCond && !stopCond && st_r == RDC_ADDR && byteDone;
  endsequence
  sequence s_dataIn;
    enable && !startCond && !stopCond && st_r == RDC_RXD && byteDone;
  endsequence

  a_addr_ack: assert property (s_addrIn |=> sdaOe_r == $past(addrHit))
    else $error("address byte acknowledge does not follow address match");
  a_data_ack: assert property (s_dataIn |=> sdaOe_r && rxValid_r && st_r == RDC_ACK)
    else $error("received byte not acknowledged and delivered");
  a_tx_msb: assert property (txTake_r |-> sdaOe_r == ~sh_r[7])
    else $error("read byte does not start with its top bit");
  a_nack_ends: assert property (st_r == RDC_MACK && sclRise && sdaS && enable && !startCond
      && !stopCond |=> st_r == RDC_IDLE && !sdaOe_r)
    else $error("controller not-acknowledge did not end the read");

endmodule : rdc_i2c_target

// *** hdl/rdc_config_top.sv ***
`timescale 1ns/100ps
`include "rdc_consts.svh"
// How it works
// - Mode strap at level zero: link and monitoring follow the two control pins.
// - Any other mode level: I2C mode; gain, link and monitoring come from registers, link and monitoring ignore their pins.
// - Pin mode gain index is four times high strap code plus low strap code.
// - In I2C mode each lane takes its own four-bit gain field.
// - Power-good rises at least the power-good delay after supply reaches minimum.
// - Straps latch at power-good rise; pull resistors drop after the hold time.
// - Target address: high strap gives bits 7..3, low strap bits 2..1.
// - Write starts with start and address with write bit; address is acknowledged.
// - One offset byte follows the address and is acknowledged.
// - Any number of data bytes follow, each acknowledged; a stop ends it.
// - Reads start at the last set offset or one past the last read; each written data byte also advances the pointer.
// - On controller acknowledge the next register is sent; stop ends the read.
// - Address plus offset then stop only moves the read pointer.
// - Set-class bits set on a written one; written zeros do nothing.
// - Clear-class bits clear on a written one; update bits change by hardware.
// - Override clear: lane fields mirror straps; set: written fields drive the lanes.
module rdc_config_top
  import rdc_pkg::*;
#(
  parameter int PG_CYCLES = `RDC_PG_DELAY_US * `RDC_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic supplyOk,
  input wire logic [1:0] modeStrap,
  input wire logic [1:0] gainStrapHigh,
  input wire logic [1:0] gainStrapLowAddrHigh,
  input wire logic [1:0] targetAddrStrapLow,
  input wire logic linkEnablePin,
  input wire logic monitorDisablePin,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic powerGood,
  output logic pullEnable,
  output logic i2cMode,
  output logic linkEnable,
  output logic monitorOn,
  output logic [3:0] laneGain0,
  output logic [3:0] laneGain1,
  output logic [3:0] laneGain2,
  output logic [3:0] laneGain3
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  localparam int HOLD_CYCLES = `RDC_HOLD_US * `RDC_CLK_MHZ;
  localparam int PGW = $clog2(PG_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);

  logic [7:0] strapSy1_r, strapSy2_r;
  logic [2:0] pinSy1_r, pinSy2_r;
  logic [PGW-1:0] pgCnt_r;
  logic [HW-1:0] holdCnt_r;
  logic powerGood_r, pullEnable_r;
  rdc_lvl_t modeLvl_r, hiLvl_r, loLvl_r, aLoLvl_r;
  logic [7:0] gen_r, mon_r, subPtr_r;
  logic [1:0] evt_r;
  logic [3:0] laneField_r [4];
  logic [3:0] laneGain_r [4];
  logic i2cMode_r, linkEnable_r, monitorOn_r, sdaOut_r;
  logic rxValid, rxFirst, txTake;
  logic [7:0] rxByte;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strapSy1_r <= 8'h00;
      strapSy2_r <= 8'h00;
      pinSy1_r <= 3'h0;
      pinSy2_r <= 3'h0;
    end else begin
      strapSy1_r <= {modeStrap, gainStrapHigh, gainStrapLowAddrHigh, targetAddrStrapLow};
      strapSy2_r <= strapSy1_r;
      pinSy1_r <= {monitorDisablePin, linkEnablePin, supplyOk};
      pinSy2_r <= pinSy1_r;
    end
  end

  wire supplyS = pinSy2_r[0];
  wire linkPinS = pinSy2_r[1];
  wire monDisS = pinSy2_r[2];
  wire pgSet = supplyS & ~powerGood_r & (pgCnt_r == PGW'(PG_CYCLES - 1));

  // Power-good delay counter; losing the supply starts the sequence over.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pgCnt_r <= '0;
      powerGood_r <= 1'b0;
    end else if (!supplyS) begin
      pgCnt_r <= '0;
      powerGood_r <= 1'b0;
    end else if (pgSet) begin
      powerGood_r <= 1'b1;
    end else if (!powerGood_r) begin
      pgCnt_r <= pgCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      modeLvl_r <= `RDC_LVL_0;
      hiLvl_r <= `RDC_LVL_0;
      loLvl_r <= `RDC_LVL_0;
      aLoLvl_r <= `RDC_LVL_0;
    end else if (pgSet) begin
      {modeLvl_r, hiLvl_r, loLvl_r, aLoLvl_r} <= strapSy2_r;
    end
  end

  // Pulls stay on until the strap hold time after power-good has passed.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt_r <= '0;
      pullEnable_r <= 1'b1;
    end else if (!supplyS) begin
      holdCnt_r <= '0;
      pullEnable_r <= 1'b1;
    end else if (powerGood_r && pullEnable_r) begin
      if (holdCnt_r == HW'(HOLD_CYCLES - 1)) begin
        pullEnable_r <= 1'b0;
      end else begin
        holdCnt_r <= holdCnt_r + 1'b1;
      end
    end
  end

  wire modeI2c = powerGood_r & (modeLvl_r != `RDC_LVL_0);
  wire [3:0] eqStrap = {hiLvl_r, loLvl_r};
  wire [4:0] addrHi = (loLvl_r == `RDC_LVL_0) ? `RDC_ADDR_L0 :
                      (loLvl_r == `RDC_LVL_R) ? `RDC_ADDR_LR :
                      (loLvl_r == `RDC_LVL_F) ? `RDC_ADDR_LF : `RDC_ADDR_L1;
  wire [6:0] devAddr = {addrHi, aLoLvl_r};
  wire override = gen_r[`RDC_GEN_OVR];
  wire wrEn = rxValid & ~rxFirst;
  wire genWr = wrEn & (subPtr_r == `RDC_OFF_GEN);
  wire eq01Wr = wrEn & (subPtr_r == `RDC_OFF_EQ01);
  wire eq23Wr = wrEn & (subPtr_r == `RDC_OFF_EQ23);
  wire monWr = wrEn & (subPtr_r == `RDC_OFF_MON);
  wire evtWr = wrEn & (subPtr_r == `RDC_OFF_EVT);
  wire [1:0] evt_nxt = {txTake | (evt_r[`RDC_EVT_RD] & ~(evtWr & rxByte[`RDC_EVT_RD])),
                        evt_r[`RDC_EVT_SW] | (evtWr & rxByte[`RDC_EVT_SW])};
  wire [7:0] monRead = {~pullEnable_r, mon_r[6:0]};
  wire [7:0] rdData = (subPtr_r == `RDC_OFF_GEN) ? gen_r :
                      (subPtr_r == `RDC_OFF_EQ01) ? {laneField_r[1], laneField_r[0]} :
                      (subPtr_r == `RDC_OFF_EQ23) ? {laneField_r[3], laneField_r[2]} :
                      (subPtr_r == `RDC_OFF_MON) ? monRead :
                      (subPtr_r == `RDC_OFF_EVT) ? {6'h00, evt_r} : 8'h00;

  rdc_i2c_target u_target (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .enable(modeI2c),
    .devAddr(devAddr),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .txData(rdData),
    .sdaOe(sdaOe),
    .rxValid(rxValid),
    .rxFirst(rxFirst),
    .rxByte(rxByte),
    .txTake(txTake)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      subPtr_r <= 8'h00;
    end else if (rxValid && rxFirst) begin
      subPtr_r <= rxByte;
    end else if (wrEn || txTake) begin
      subPtr_r <= subPtr_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gen_r <= `RDC_GEN_RST;
      mon_r <= 8'h00;
      evt_r <= 2'h0;
    end else begin
      if (genWr) begin
        gen_r <= rxByte & `RDC_GEN_WMASK;
      end
      if (monWr) begin
        mon_r <= rxByte;
      end
      evt_r <= evt_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        laneField_r[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!override) begin
          laneField_r[i] <= eqStrap;
        end else if ((i < 2) ? eq01Wr : eq23Wr) begin
          laneField_r[i] <= i[0] ? rxByte[7:4] : rxByte[3:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      i2cMode_r <= 1'b0;
      linkEnable_r <= 1'b0;
      monitorOn_r <= 1'b0;
      sdaOut_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        laneGain_r[i] <= 4'h0;
      end
    end else begin
      i2cMode_r <= modeI2c;
      linkEnable_r <= modeI2c ? (gen_r[1:0] == `RDC_LINK_ON) : powerGood_r & linkPinS;
      monitorOn_r <= modeI2c ? ~mon_r[`RDC_MON_DIS] : powerGood_r & ~monDisS;
      sdaOut_r <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        laneGain_r[i] <= modeI2c ? laneField_r[i] : eqStrap;
      end
    end
  end

  assign sdaOut = sdaOut_r;
  assign powerGood = powerGood_r;
  assign pullEnable = pullEnable_r;
  assign i2cMode = i2cMode_r;
  assign linkEnable = linkEnable_r;
  assign monitorOn = monitorOn_r;
  assign laneGain0 = laneGain_r[0];
  assign laneGain1 = laneGain_r[1];
  assign laneGain2 = laneGain_r[2];
  assign laneGain3 = laneGain_r[3];

  logic [15:0] upCnt_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      upCnt_r <= 16'h0000;
    end else if (!supplyS) begin
      upCnt_r <= 16'h0000;
    end else if (upCnt_r != 16'hFFFF) begin
      upCnt_r <= upCnt_r + 16'h0001;
    end
  end

  a_pg_delay: assert property ($rose(powerGood_r) |-> upCnt_r == 16'(PG_CYCLES))
    else $error("power-good did not rise at the delay count");
  a_strap_latch: assert property ($rose(powerGood_r) |-> modeLvl_r == $past(strapSy2_r[7:6]))
    else $error("mode strap not latched at power-good rise");
  a_pull_off: assert property ($fell(pullEnable_r) && supplyS
      |-> upCnt_r == 16'(PG_CYCLES + HOLD_CYCLES))
    else $error("pulls released at the wrong time");
  a_pin_link: assert property (powerGood_r && !modeI2c ##1 !modeI2c
      |-> linkEnable_r == $past(linkPinS) && monitorOn_r == !$past(monDisS))
    else $error("pin mode link or monitor does not follow pins");
  a_i2c_link: assert property (modeI2c ##1 modeI2c
      |-> linkEnable_r == ($past(gen_r[1:0]) == `RDC_LINK_ON))
    else $error("register mode link enable wrong");
  a_pin_gain: assert property (!modeI2c |=> laneGain_r[2] == $past(eqStrap))
    else $error("pin mode gain index wrong");
  a_lane_write: assert property (override && eq23Wr |=> laneField_r[3] == $past(rxByte[7:4]))
    else $error("lane field write lost");
  a_gain_mirror: assert property (!override |=> laneField_r[0] == $past(eqStrap))
    else $error("lane field does not mirror straps");
  a_ptr_set: assert property (rxValid && rxFirst |=> subPtr_r == $past(rxByte))
    else $error("offset byte did not set the pointer");
  a_ptr_step: assert property ((wrEn || txTake) && !rxFirst
      |=> subPtr_r == $past(subPtr_r) + 8'h01)
    else $error("pointer did not advance");
  a_set_bit: assert property (evtWr && rxByte[0] |=> evt_r[`RDC_EVT_SW])
    else $error("set-class bit not set");
  a_clr_bit: assert property (evtWr && rxByte[1] && !txTake |=> !evt_r[`RDC_EVT_RD])
    else $error("clear-class bit not cleared");

endmodule : rdc_config_top

// *** dv/rdc_i2c_ctrl.sv ***
`timescale 1ns/100ps
module rdc_i2c_ctrl (
  input wire logic clk_sys,
  input wire logic sdaLine,
  output logic sclLow,
  output logic sdaLow
);
  // Both lines are open drain, so a released line reads high through its pull-up.
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // SDA falls while SCL is high.
  task automatic start_cond();
    sdaLow <= 1'b0;
    tick(4);
    sclLow <= 1'b0;
    tick(8);
    sdaLow <= 1'b1;
    tick(8);
    sclLow <= 1'b1;
    tick(4);
  endtask : start_cond

  // SDA rises while SCL is high.
  task automatic stop_cond();
    sdaLow <= 1'b1;
    tick(4);
    sclLow <= 1'b0;
    tick(8);
    sdaLow <= 1'b0;
    tick(8);
  endtask : stop_cond

  // Sends a byte MSB first, then the ninth bit; ackOut high releases SDA for the ninth bit.
  task automatic xfer(input logic [7:0] d, input logic ackOut, output logic [7:0] r,
                      output logic ackIn);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, ackOut};
    for (int i = 8; i >= 0; i--) begin
      sdaLow <= ~tx[i];
      tick(4);
      sclLow <= 1'b0;
      tick(4);
      rx[i] = sdaLine;
      tick(4);
      sclLow <= 1'b1;
      tick(4);
    end
    r = rx[8:1];
    ackIn = rx[0];
  endtask : xfer
endmodule : rdc_i2c_ctrl

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`include "rdc_consts.svh"
module tb_top
  import rdc_pkg::*;
;
  localparam int PGC = 20;
  localparam logic [6:0] DEV = {`RDC_ADDR_LR, 2'h2};
  logic clk_sys, arst_n, supplyOk, linkEnablePin, monitorDisablePin;
  logic [1:0] modeStrap, gainStrapHigh, gainStrapLowAddrHigh, targetAddrStrapLow;
  logic sdaOut, sdaOe, powerGood, pullEnable, i2cMode, linkEnable, monitorOn;
  logic [3:0] laneGain0, laneGain1, laneGain2, laneGain3;
  logic sclLow, sdaLow, sclIn, sdaIn;
  logic [7:0] q0, q1;
  int errCount = 0;
  int checks = 0;
  int n;

  assign sclIn = ~sclLow;
  assign sdaIn = ~(sdaLow | (sdaOe & ~sdaOut));

  rdc_config_top #(.PG_CYCLES(PGC)) rdc_config_top_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .supplyOk(supplyOk), .modeStrap(modeStrap), .gainStrapHigh(gainStrapHigh),
    .gainStrapLowAddrHigh(gainStrapLowAddrHigh), .targetAddrStrapLow(targetAddrStrapLow),
    .linkEnablePin(linkEnablePin), .monitorDisablePin(monitorDisablePin), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .powerGood(powerGood),
    .pullEnable(pullEnable), .i2cMode(i2cMode), .linkEnable(linkEnable),
    .monitorOn(monitorOn), .laneGain0(laneGain0), .laneGain1(laneGain1),
    .laneGain2(laneGain2), .laneGain3(laneGain3));

  rdc_i2c_ctrl rdc_i2c_ctrl_inst (.clk_sys(clk_sys), .sdaLine(sdaIn), .sclLow(sclLow),
    .sdaLow(sdaLow));

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  task automatic completeRun();
    if (errCount == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : completeRun

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_lanes(input logic [15:0] exp);
    chk("lanes10", exp[7:0], {laneGain1, laneGain0});
    chk("lanes32", exp[15:8], {laneGain3, laneGain2});
  endtask : chk_lanes

  // Brings the supply up and checks how long power-good and the strap pulls take.
  task automatic power_up();
    @(posedge clk_sys);
    supplyOk <= 1'b1;
    n = 0;
    while (powerGood !== 1'b1 && n < PGC + 50) begin
      @(negedge clk_sys);
      n++;
    end
    chk("pgInTime", 8'h01, 8'((n > PGC) && (n <= PGC + 5)));
    if (powerGood !== 1'b1) completeRun();
    n = 0;
    while (pullEnable === 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    chk("pullHold", 8'd250, n[7:0]);
  endtask : power_up

  task automatic reg_write(input logic [7:0] off, input int cnt, input logic [7:0] d0,
                           input logic [7:0] d1);
    logic [7:0] r;
    logic a;
    rdc_i2c_ctrl_inst.start_cond();
    rdc_i2c_ctrl_inst.xfer({DEV, 1'b0}, 1'b1, r, a);
    chk("ackAddrW", 8'h00, {7'h00, a});
    rdc_i2c_ctrl_inst.xfer(off, 1'b1, r, a);
    chk("ackOff", 8'h00, {7'h00, a});
    for (int i = 0; i < cnt; i++) begin
      rdc_i2c_ctrl_inst.xfer((i == 0) ? d0 : d1, 1'b1, r, a);
      chk("ackData", 8'h00, {7'h00, a});
    end
    rdc_i2c_ctrl_inst.stop_cond();
  endtask : reg_write

  // Reads two bytes when two is set, acknowledging the first and refusing the last.
  task automatic reg_read(input logic two, output logic [7:0] b0, output logic [7:0] b1);
    logic a;
    rdc_i2c_ctrl_inst.start_cond();
    rdc_i2c_ctrl_inst.xfer({DEV, 1'b1}, 1'b1, b0, a);
    chk("ackAddrR", 8'h00, {7'h00, a});
    rdc_i2c_ctrl_inst.xfer(8'hFF, ~two, b0, a);
    if (two) rdc_i2c_ctrl_inst.xfer(8'hFF, 1'b1, b1, a);
    rdc_i2c_ctrl_inst.stop_cond();
  endtask : reg_read

  initial begin
    arst_n = 1'b0;
    supplyOk = 1'b0;
    modeStrap = 2'h0;
    gainStrapHigh = 2'h2;
    gainStrapLowAddrHigh = 2'h1;
    targetAddrStrapLow = 2'h2;
    linkEnablePin = 1'b1;
    monitorDisablePin = 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("pgReset", 8'h00, {7'h00, powerGood});
    chk("pullReset", 8'h01, {7'h00, pullEnable});
    arst_n <= 1'b1;
    power_up();
    chk("pinMode", 8'h00, {7'h00, i2cMode});
    chk("pinLink", 8'h01, {7'h00, linkEnable});
    chk("pinMon", 8'h01, {7'h00, monitorOn});
    chk_lanes(16'h9999);
    @(posedge clk_sys);
    linkEnablePin <= 1'b0;
    monitorDisablePin <= 1'b1;
    gainStrapHigh <= 2'h0;
    repeat (6) @(negedge clk_sys);
    chk("pinLinkOff", 8'h00, {7'h00, linkEnable});
    chk("pinMonOff", 8'h00, {7'h00, monitorOn});
    chk_lanes(16'h9999);
    @(posedge clk_sys);
    supplyOk <= 1'b0;
    repeat (5) @(posedge clk_sys);
    modeStrap <= 2'h3;
    gainStrapHigh <= 2'h3;
    repeat (5) @(posedge clk_sys);
    power_up();
    chk("i2cMode", 8'h01, {7'h00, i2cMode});
    chk("linkOff", 8'h00, {7'h00, linkEnable});
    chk("i2cMon", 8'h01, {7'h00, monitorOn});
    chk_lanes(16'hDDDD);
    rdc_i2c_ctrl_inst.start_cond();
    rdc_i2c_ctrl_inst.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, q0, q1[0]);
    chk("nackOther", 8'h01, {7'h00, q1[0]});
    rdc_i2c_ctrl_inst.stop_cond();
    chk("sdaOut", 8'h00, {7'h00, sdaOut});
    reg_write(`RDC_OFF_GEN, 1, 8'h12, 8'h00);
    reg_write(`RDC_OFF_EQ01, 2, 8'h21, 8'h43);
    repeat (4) @(negedge clk_sys);
    chk("linkOn", 8'h01, {7'h00, linkEnable});
    chk_lanes(16'h4321);
    reg_write(`RDC_OFF_EQ23, 0, 8'h00, 8'h00);
    chk_lanes(16'h4321);
    reg_read(1'b1, q0, q1);
    chk("rdEq23", 8'h43, q0);
    chk("rdMon", 8'h80, q1);
    reg_read(1'b0, q0, q1);
    chk("rdNext", 8'h00, q0);
    reg_write(`RDC_OFF_EVT, 1, 8'h01, 8'h00);
    reg_write(`RDC_OFF_EVT, 1, 8'h00, 8'h00);
    reg_write(`RDC_OFF_EVT, 0, 8'h00, 8'h00);
    reg_read(1'b0, q0, q1);
    chk("evtSet", 8'h01, q0 & 8'h01);
    chk("evtHw", 8'h02, q0 & 8'h02);
    reg_write(`RDC_OFF_EVT, 1, 8'h02, 8'h00);
    reg_write(`RDC_OFF_EVT, 0, 8'h00, 8'h00);
    reg_read(1'b0, q0, q1);
    chk("evtClr", 8'h01, q0);
    reg_write(`RDC_OFF_MON, 1, 8'h01, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk("i2cMonOff", 8'h00, {7'h00, monitorOn});
    completeRun();
  end
endmodule : tb_top
